// *** verilog/ppsc_pkg.sv ***
package ppsc_pkg;
   // configuration offsets of the two registers
   localparam logic [7:0] PPSC_OFS_PMCS = 8'ha4;
   localparam logic [7:0] PPSC_OFS_BRX = 8'ha6;
   // control/status and bridge field positions
   localparam int PPSC_BIT_WSTAT = 15;
   localparam int PPSC_BIT_WEN = 8;
   localparam int PPSC_BIT_BPCC = 7;
   localparam int PPSC_BIT_D3ACT = 6;
   localparam logic [15:0] PPSC_PMCS_RST = 16'h0000;
   localparam logic [7:0] PPSC_BRX_RST = 8'hc0;
   localparam logic [1:0] PPSC_D0 = 2'h0;
   localparam logic [1:0] PPSC_D1 = 2'h1;
   localparam logic [1:0] PPSC_D2 = 2'h2;
   localparam logic [1:0] PPSC_D3HOT = 2'h3;

   // configuration access request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } ppsc_req_type;

   // secondary bus controls
   typedef struct packed {
      logic clk_stop;
      logic pwr_off;
   } ppsc_sec_type;
endpackage : ppsc_pkg

// *** verilog/ppsc_wake.sv ***
`timescale 1ns/100ps
module ppsc_wake
   import ppsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic event_i,
   input wire logic clear_i,
   input wire logic enable_i,
   output logic status_o,
   output logic wake_o
);
   typedef struct packed {
      logic stat;
   } ppsc_wk_type;
   ppsc_wk_type st_reg;
   ppsc_wk_type st_next;

   // set wins over a same-cycle clear so no event is lost
   always_comb begin
      st_next = st_reg;
      if (clear_i) begin
         st_next.stat = 1'b0; // [R4]
      end
      if (event_i) begin
         st_next.stat = 1'b1; // [R3]
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign status_o = st_reg.stat;
   assign wake_o = st_reg.stat & enable_i; // [R16] [R7]

   AST_WAKE_SET: assert property (@(posedge clk_i) disable iff (!nrst_i)
      event_i |=> status_o) else $error("wake flag not set"); // [R3]
   AST_WAKE_CLR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (clear_i && !event_i) |=> !status_o && !wake_o) else $error("wake clear failed"); // [R4]
endmodule : ppsc_wake

// *** verilog/ppsc_secbus.sv ***
`timescale 1ns/100ps
module ppsc_secbus
   import ppsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [1:0] pstate_i,
   input wire logic bus_power_clock_ctrl_enable_i,
   input wire logic d3act_i,
   output ppsc_sec_type sec_o
);
   typedef struct packed {
      ppsc_sec_type sec;
   } ppsc_sb_type;
   ppsc_sb_type st_reg;
   ppsc_sb_type st_next;

   // secondary bus action only follows power state while control is enabled
   always_comb begin
      st_next = '0;
      if (bus_power_clock_ctrl_enable_i && pstate_i == PPSC_D3HOT) begin // [R13] [R15]
         st_next.sec.clk_stop = d3act_i; // [R14]
         st_next.sec.pwr_off = ~d3act_i; // [R14]
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sec_o = st_reg.sec;

   AST_SEC_GATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !bus_power_clock_ctrl_enable_i |=> sec_o == '0) else $error("secondary bus moved while disabled"); // [R13]
   AST_SEC_D3: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (bus_power_clock_ctrl_enable_i && pstate_i == PPSC_D3HOT && d3act_i) |=> sec_o.clk_stop && !sec_o.pwr_off)
      else $error("clock not stopped in d3hot"); // [R14] [R15]
endmodule : ppsc_secbus

// *** verilog/ppsc_ctrl.sv ***
// Summary of operation
// [R1] control/status contents survive the internal d3hot-to-d0 function reset
// [R2] d3hot-to-d0 pulses a function reset, sparing wake context and global bits
// [R3] wake status flag sets on any wake event, whatever the enable
// [R4] writing 1 clears the wake flag and its wake output; 0 does nothing
// [R5] data scale field bits 14..13 read zero
// [R6] data select field bits 12..9 read zero
// [R7] wake enable bit 8 is read/write and gates the wake output
// [R8] dynamic data wake enable bit 4 reads zero
// [R9] reserved control bits and bridge bits 5..0 read zero
// [R10] power state encoding: 00 d0, 01 d1, 10 d2, 11 d3hot
// [R11] power state field reads current state, written to change it
// [R12] bridge bus power/clock control enable bit 7 reads BUS_POWER_CLOCK_CTRL_ENABLE_VAL, one by default
// [R13] with control disabled power state does not steer secondary bus
// [R14] bridge bit 6: one stops secondary clock, zero removes power
// [R15] bit 6 acts only while bit 7 is one
// [R16] wake output active only while flag and enable are both set
`timescale 1ns/100ps
module ppsc_ctrl
   import ppsc_pkg::*;
#(
   parameter logic BUS_POWER_CLOCK_CTRL_ENABLE_VAL = 1'b1,
   parameter logic D3ACT_VAL = 1'b1
)
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input ppsc_req_type req_i,
   input wire logic wake_event_i,
   output logic [31:0] rdata_o,
   output logic rvalid_o,
   output logic wake_o,
   output logic func_rst_o,
   output logic [1:0] power_state_o,
   output ppsc_sec_type sec_o
);
   typedef struct packed {
      logic [1:0] pstate;
      logic wen;
      logic [31:0] rdata;
      logic rvalid;
      logic frst;
   } ppsc_st_type;
   ppsc_st_type st_reg;
   ppsc_st_type st_next;

   logic hit;
   logic wr_lo;
   logic wr_hi;
   logic wake_clr;
   logic wake_stat;
   logic [15:0] pmcs_view;
   logic [7:0] brx_view;

   // dword containing both registers; byte enables pick the lanes
   function automatic logic dword_hit(input logic [7:0] a);
      return a[7:2] == PPSC_OFS_PMCS[7:2];
   endfunction : dword_hit

   assign hit = dword_hit(req_i.addr);
   assign wr_lo = req_i.wr & hit & req_i.be[0];
   assign wr_hi = req_i.wr & hit & req_i.be[1];
   assign wake_clr = wr_hi & req_i.wdata[PPSC_BIT_WSTAT]; // [R4]

   // unimplemented fields are tied low in the read view
   always_comb begin
      pmcs_view = '0; // [R5] [R6] [R8] [R9]
      pmcs_view[PPSC_BIT_WSTAT] = wake_stat;
      pmcs_view[PPSC_BIT_WEN] = st_reg.wen;
      pmcs_view[1:0] = st_reg.pstate; // [R10] [R11]
      brx_view = '0; // [R9]
      brx_view[PPSC_BIT_BPCC] = BUS_POWER_CLOCK_CTRL_ENABLE_VAL; // [R12]
      brx_view[PPSC_BIT_D3ACT] = D3ACT_VAL; // [R14]
   end

   // register updates; the function reset never touches this register
   always_comb begin
      st_next = st_reg;
      st_next.rvalid = req_i.rd;
      st_next.frst = 1'b0;
      if (req_i.rd) begin
         // bridge byte sits in lane 2 (offset 0xa6); lane 3 is unused and reads zero
         st_next.rdata = hit ? {8'h00, brx_view & {8{req_i.be[2]}}, pmcs_view} : '0;
         if (hit) begin
            st_next.rdata[7:0] = pmcs_view[7:0] & {8{req_i.be[0]}};
            st_next.rdata[15:8] = pmcs_view[15:8] & {8{req_i.be[1]}};
         end
      end
      if (wr_hi) begin
         st_next.wen = req_i.wdata[PPSC_BIT_WEN]; // [R7]
      end
      if (wr_lo) begin
         st_next.pstate = req_i.wdata[1:0]; // [R11]
         st_next.frst = (st_reg.pstate == PPSC_D3HOT) &&
                        (req_i.wdata[1:0] == PPSC_D0); // [R2]
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next; // [R1]
      end
   end

   ppsc_wake u_wake (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .event_i(wake_event_i),
      .clear_i(wake_clr),
      .enable_i(st_reg.wen),
      .status_o(wake_stat),
      .wake_o(wake_o)
   );

   ppsc_secbus u_sec (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .pstate_i(st_reg.pstate),
      .bus_power_clock_ctrl_enable_i(BUS_POWER_CLOCK_CTRL_ENABLE_VAL),
      .d3act_i(D3ACT_VAL),
      .sec_o(sec_o)
   );

   assign rdata_o = st_reg.rdata;
   assign rvalid_o = st_reg.rvalid;
   assign func_rst_o = st_reg.frst;
   assign power_state_o = st_reg.pstate;

   AST_PSTATE_WR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_lo |=> power_state_o == $past(req_i.wdata[1:0])) else $error("state not written"); // [R11]
   AST_FRST: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr_lo && power_state_o == PPSC_D3HOT && req_i.wdata[1:0] == PPSC_D0) |=> func_rst_o)
      else $error("no function reset"); // [R2]
   AST_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (func_rst_o && !wr_lo && !wr_hi) |=> $stable(power_state_o) && $stable(st_reg.wen))
      else $error("register changed by function reset"); // [R1]
   AST_WEN_WR: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wr_hi |=> st_reg.wen == $past(req_i.wdata[PPSC_BIT_WEN])) else $error("enable not written"); // [R7]
   AST_WAKE_GATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
      wake_o |-> wake_stat && st_reg.wen) else $error("wake without flag and enable"); // [R16]
   AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (req_i.rd && hit) |=> rdata_o[14:9] == '0 && rdata_o[7:2] == '0 && rdata_o[21:16] == '0
      && rdata_o[31:24] == '0)
      else $error("fixed fields not zero"); // [R5] [R6] [R8] [R9]
   AST_BRX_RD: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (req_i.rd && hit && req_i.be[2]) |=> rdata_o[23] == BUS_POWER_CLOCK_CTRL_ENABLE_VAL)
      else $error("bridge enable bit wrong"); // [R12]
   AST_RVALID: assert property (@(posedge clk_i) disable iff (!nrst_i)
      req_i.rd |=> rvalid_o ##1 !rvalid_o || $past(req_i.rd)) else $error("read answer timing"); // [R11]
endmodule : ppsc_ctrl

// *** dv/ppsc_host.sv ***
`timescale 1ns/100ps
module ppsc_host
   import ppsc_pkg::*;
(
   input wire logic clk_i,
   input wire logic [31:0] rdata_i,
   output ppsc_req_type req_o,
   output logic wake_event_o
);
   // bus idle at time zero
   initial begin
      req_o = '0;
      wake_event_o = 1'b0;
   end
   // one-cycle strobe; address and data turn over afterwards so stale values never match
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
         input logic [31:0] d);
      @(negedge clk_i);
      req_o = '{rd: ~w, wr: w, addr: a, be: b, wdata: d};
      @(negedge clk_i);
      req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: ~b, wdata: ~d};
   endtask : xfer
   // software moves the function by writing the state field
   task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
      xfer(1'b1, a, b, d);
   endtask : cfg_wr
   // answer stands one cycle after the strobe edge
   task automatic cfg_rd(input logic [7:0] a, input logic [3:0] b, output logic [31:0] d);
      xfer(1'b0, a, b, 32'h0);
      d = rdata_i;
   endtask : cfg_rd
   task automatic wake_pulse();
      @(negedge clk_i);
      wake_event_o = 1'b1;
      @(negedge clk_i);
      wake_event_o = 1'b0;
   endtask : wake_pulse
endmodule : ppsc_host

// *** dv/pci_power_state_control_tb.sv ***
`timescale 1ns/100ps
module pci_power_state_control_tb;
   import ppsc_pkg::*;
   logic clk_i = 1'b0;
   logic nrst_i = 1'b0;
   ppsc_req_type req;
   logic ev, rv, wake, frst;
   logic [31:0] rdata, rd;
   logic [1:0] ps;
   ppsc_sec_type sec, sec_b3, sec_nb;
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   localparam logic [7:0] A = PPSC_OFS_PMCS;

   ppsc_host u_host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req), .wake_event_o(ev));
   ppsc_ctrl u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req), .wake_event_i(ev),
      .rdata_o(rdata), .rvalid_o(rv), .wake_o(wake), .func_rst_o(frst),
      .power_state_o(ps), .sec_o(sec));
   // variant where d3hot removes secondary power
   ppsc_ctrl #(.D3ACT_VAL(1'b0)) u_b3 (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
      .wake_event_i(ev), .rdata_o(), .rvalid_o(), .wake_o(), .func_rst_o(),
      .power_state_o(), .sec_o(sec_b3));
   // variant with bus power/clock control off
   ppsc_ctrl #(.BUS_POWER_CLOCK_CTRL_ENABLE_VAL(1'b0)) u_nb (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req),
      .wake_event_i(ev), .rdata_o(), .rvalid_o(), .wake_o(), .func_rst_o(),
      .power_state_o(), .sec_o(sec_nb));

   initial forever #2 clk_i = ~clk_i;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish

   // watchdog: the sequence needs well under 200 cycles
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : check

   task automatic rd_chk(input logic [7:0] a, input logic [3:0] b, input logic [31:0] exp);
      u_host.cfg_rd(a, b, rd);
      check({31'h0, rv}, 32'h1);
      check(rd, exp);
   endtask : rd_chk

   initial begin
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      nrst_i = 1'b1;
      check({29'h0, frst, ps}, 32'h0);
      rd_chk(A, 4'hf, {8'h00, PPSC_BRX_RST, 16'h0000});
      $display("test reset done");
      u_host.cfg_wr(A, 4'hf, 32'hffffffff);
      rd_chk(A, 4'hf, 32'h00c00103);
      check({30'h0, sec}, 32'h2);
      check({30'h0, sec_b3}, 32'h1);
      check({30'h0, sec_nb}, 32'h0);
      $display("test read_only done");
      // state 3 to 0 fires the function reset but spares this register
      for (int s = 0; s < 4; s++) begin
         u_host.cfg_wr(A, 4'h1, 32'(s));
         check({31'h0, frst}, {31'h0, s == 0});
         check({30'h0, ps}, 32'(s));
         rd_chk(A, 4'h3, 32'h100 | 32'(s));
      end
      $display("test states done");
      u_host.wake_pulse();
      check({31'h0, wake}, 32'h1);
      u_host.cfg_wr(A, 4'h2, 32'h00000100);
      rd_chk(A, 4'h3, 32'h00008103);
      u_host.cfg_wr(A, 4'h2, 32'h00008100);
      rd_chk(A, 4'h3, 32'h00000103);
      check({31'h0, wake}, 32'h0);
      u_host.cfg_wr(A, 4'h2, 32'h0);
      u_host.wake_pulse();
      rd_chk(A, 4'h3, 32'h00008003);
      check({31'h0, wake}, 32'h0);
      u_host.cfg_wr(A, 4'h2, 32'h00000100);
      check({31'h0, wake}, 32'h1);
      $display("test wake done");
      u_host.cfg_wr(8'ha8, 4'hf, 32'h0);
      rd_chk(8'ha8, 4'hf, 32'h0);
      rd_chk(A, 4'h3, 32'h00008103);
      $display("test miss done");
      tally_and_finish();
   end
endmodule : pci_power_state_control_tb
